// ---- hdl/host_port_nonmux.sv ----
// Separate address/data host port with APB register slave.
// Assumes host pins synchronous to pclk; DMA side grants with held request.
`timescale 1ns/10ps
module host_port_nonmux (
  input wire logic pclk,                  // Device CPU clock
  input wire logic presetn,               // Global reset, low active
  input wire logic sub_a_resetn,          // First-subsystem reset, low active
  input wire logic port_resetn,           // Host port own reset, low active
  input wire logic [11:0] paddr,          // APB byte address
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB access phase
  input wire logic pwrite,                // APB direction
  input wire logic [31:0] pwdata,         // APB write data
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error
  input wire logic [18:0] host_address_bus_i, // Host address in
  input wire logic host_address_bus_oe_ext, // Some party drives address bus
  output logic [18:0] host_address_bus_o, // Address holder drive
  output logic host_address_bus_oe,       // Address holder enable
  input wire logic [15:0] host_data_bus_i, // Host data in
  output logic [15:0] host_data_bus_o,    // Host data out
  output logic host_data_bus_oe,          // Data bus drive enable
  input wire logic host_data_bus_host_oe, // Host drives data bus
  input wire logic host_data_strobe_one_n, // Data strobe one, low active
  input wire logic host_data_strobe_two_n, // Data strobe two, low active
  input wire logic host_chip_select_n,    // Chip select, low active
  input wire logic host_read_write,       // High read, low write
  output logic host_ready,                // High when access may finish
  input wire logic port_select_low,       // Subsystem select lower pin
  input wire logic port_select_high,      // Subsystem select upper pin
  input wire logic cpu_idle,              // CPU in idle one or two
  input wire logic cpu_halted,            // CPU halted by emulation
  output logic mem_clk_en,                // Memory clock request
  output logic [3:0] sub_req,             // DMA request per subsystem
  output logic sub_wr,                    // DMA write
  output logic sub_shared,                // DMA to shared program memory
  output logic [17:0] sub_addr,           // DMA word address
  output logic [15:0] sub_wdata,          // DMA write data
  input wire logic [3:0] sub_gnt,         // DMA grant per subsystem
  input wire logic [63:0] sub_rdata       // DMA read data per subsystem
);

  // ---------------------------------------------------------------
  // Resets
  // ---------------------------------------------------------------
  // Register file clears on global or subsystem A reset
  logic reg_rst_n;
  // Port core clears on global or its own reset; the CPU reset is not here
  logic port_rst_n;
  assign reg_rst_n = presetn & sub_a_resetn;
  assign port_rst_n = presetn & port_resetn;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] bank_ctrl_reg;
  logic [15:0] mmr_limit_reg;
  logic [15:0] rdata_reg;
  logic reject_reg;
  logic [15:0] access_count_reg;
  host_port_pkg::host_state_t state_reg;
  logic apb_wr;
  logic data_hold_en;
  logic addr_hold_en;

  // Zero wait state slave: pready high in every access phase
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign data_hold_en = bank_ctrl_reg[host_port_pkg::BANK_DATA_HOLD_BIT];
  assign addr_hold_en = bank_ctrl_reg[host_port_pkg::BANK_ADDR_HOLD_BIT];

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == host_port_pkg::BANK_CTRL_ADDR) ||
                 (a == host_port_pkg::PORT_STATUS_ADDR) ||
                 (a == host_port_pkg::MMR_LIMIT_ADDR);
  endfunction

  // Bank control write; reserved bits never store
  always_ff @(posedge pclk or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      bank_ctrl_reg <= host_port_pkg::BANK_CTRL_RESET;
    end else if (apb_wr && paddr == host_port_pkg::BANK_CTRL_ADDR) begin
      bank_ctrl_reg <= pwdata[15:0] & host_port_pkg::BANK_CTRL_MASK;
    end
  end

  // Top of the register area the host must not reach
  always_ff @(posedge pclk or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      mmr_limit_reg <= host_port_pkg::MMR_LIMIT_RESET;
    end else if (apb_wr && paddr == host_port_pkg::MMR_LIMIT_ADDR) begin
      mmr_limit_reg <= pwdata[15:0];
    end
  end

  // Read mux; unmapped addresses read zero and flag pslverr
  always_comb begin
    prdata = 32'h00000000;
    pslverr = psel & penable & ~addr_known(paddr);
    case (paddr)
      host_port_pkg::BANK_CTRL_ADDR: prdata = {16'h0000, bank_ctrl_reg};
      host_port_pkg::PORT_STATUS_ADDR: prdata = {access_count_reg, 8'h00, reject_reg,
                                                 host_ready, port_select_high, port_select_low,
                                                 1'b0, state_reg};
      host_port_pkg::MMR_LIMIT_ADDR: prdata = {16'h0000, mmr_limit_reg};
      default: prdata = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Host access sequencer
  // ---------------------------------------------------------------
  logic strobe;
  logic [17:0] acc_addr_reg;
  logic acc_shared_reg;
  logic acc_wr_reg;
  logic [15:0] acc_wdata_reg;
  logic is_mmr;
  dma_link_if link ();

  // Both strobes and chip select must be low for an access
  assign strobe = ~host_chip_select_n & ~host_data_strobe_one_n & ~host_data_strobe_two_n;
  // Register area sits only in local data page 0
  assign is_mmr = ~host_address_bus_i[host_port_pkg::SPACE_BIT] &&
                  host_address_bus_i[17:16] == 2'h0 &&
                  host_address_bus_i[15:0] <= mmr_limit_reg;

  // Idle and halt do not gate the port: no CPU state enters the sequencer
  always_ff @(posedge pclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      state_reg <= host_port_pkg::HP_IDLE;
    end else begin
      case (state_reg)
        host_port_pkg::HP_IDLE: begin
          if (strobe && is_mmr) begin
            state_reg <= host_port_pkg::HP_REJECT;
          end else if (strobe) begin
            state_reg <= host_port_pkg::HP_WAKE;
          end
        end
        // One cycle for the memory clocks to come up
        host_port_pkg::HP_WAKE: state_reg <= host_port_pkg::HP_DMA;
        host_port_pkg::HP_DMA: begin
          if (link.gnt) begin
            state_reg <= host_port_pkg::HP_DONE;
          end
        end
        host_port_pkg::HP_DONE, host_port_pkg::HP_REJECT: begin
          if (!strobe) begin
            state_reg <= host_port_pkg::HP_IDLE;
          end
        end
        default: state_reg <= host_port_pkg::HP_IDLE;
      endcase
    end
  end

  // Capture the access at the strobe; address split on bit 18
  always_ff @(posedge pclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      acc_addr_reg <= 18'h00000;
      acc_shared_reg <= 1'b0;
      acc_wr_reg <= 1'b0;
      acc_wdata_reg <= 16'h0000;
    end else if (state_reg == host_port_pkg::HP_IDLE && strobe) begin
      acc_addr_reg <= host_address_bus_i[17:0];
      acc_shared_reg <= host_address_bus_i[host_port_pkg::SPACE_BIT];
      acc_wr_reg <= ~host_read_write;
      acc_wdata_reg <= host_data_bus_i;
    end
  end

  // Read data returned by the DMA; rejected reads return zero
  always_ff @(posedge pclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (state_reg == host_port_pkg::HP_DMA && link.gnt && !acc_wr_reg) begin
      rdata_reg <= link.rdata;
    end else if (state_reg == host_port_pkg::HP_IDLE && strobe && is_mmr) begin
      rdata_reg <= 16'h0000;
    end
  end

  // Sticky reject flag and access counter for software visibility
  always_ff @(posedge pclk or negedge port_rst_n) begin
    if (!port_rst_n) begin
      reject_reg <= 1'b0;
      access_count_reg <= 16'h0000;
    end else begin
      if (state_reg == host_port_pkg::HP_IDLE && strobe && is_mmr) begin
        reject_reg <= 1'b1;
      end else if (apb_wr && paddr == host_port_pkg::PORT_STATUS_ADDR && pwdata[7]) begin
        reject_reg <= 1'b0;
      end
      if (state_reg == host_port_pkg::HP_DMA && link.gnt) begin
        access_count_reg <= access_count_reg + 16'h0001;
      end
    end
  end

  // Every host access outside the register window is one DMA transaction; no control-register path exists
  assign link.req = (state_reg == host_port_pkg::HP_DMA);
  assign link.wr = acc_wr_reg;
  assign link.shared = acc_shared_reg;
  assign link.addr = acc_addr_reg;
  assign link.wdata = acc_wdata_reg;
  assign sub_wr = link.wr;
  assign sub_shared = link.shared;
  assign sub_addr = link.addr;
  assign sub_wdata = link.wdata;

  // Clocks run from wake through the DMA, and always while the CPU is not idle or is halted
  assign mem_clk_en = (state_reg == host_port_pkg::HP_WAKE) ||
                      (state_reg == host_port_pkg::HP_DMA) || ~cpu_idle | cpu_halted;

  // Ready low until the DMA has answered or the access is refused
  assign host_ready = (state_reg == host_port_pkg::HP_DONE) ||
                      (state_reg == host_port_pkg::HP_REJECT) ||
                      (state_reg == host_port_pkg::HP_IDLE && !strobe);

  subsys_select u_sel (
    .sel({port_select_high, port_select_low}),
    .link(link),
    .sub_req(sub_req),
    .sub_gnt(sub_gnt),
    .sub_rdata(sub_rdata)
  );

  // ---------------------------------------------------------------
  // Bus holders
  // ---------------------------------------------------------------
  logic [15:0] data_last_reg;
  logic [18:0] addr_last_reg;

  // Remember last driven levels; holders keep them while nobody drives
  always_ff @(posedge pclk or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      data_last_reg <= 16'h0000;
      addr_last_reg <= 19'h00000;
    end else begin
      if (host_data_bus_host_oe) begin
        data_last_reg <= host_data_bus_i;
      end else if (host_data_bus_oe) begin
        data_last_reg <= host_data_bus_o;
      end
      if (host_address_bus_oe_ext) begin
        addr_last_reg <= host_address_bus_i;
      end
    end
  end

  // Read data drive wins over the holder; holder only when bus is floating
  always_comb begin
    if (state_reg == host_port_pkg::HP_DONE && !acc_wr_reg && strobe && host_read_write) begin
      host_data_bus_o = rdata_reg;
      host_data_bus_oe = 1'b1;
    end else if (state_reg == host_port_pkg::HP_REJECT && strobe && host_read_write) begin
      host_data_bus_o = rdata_reg;
      host_data_bus_oe = 1'b1;
    end else begin
      host_data_bus_o = data_last_reg;
      host_data_bus_oe = data_hold_en & ~host_data_bus_host_oe;
    end
  end

  assign host_address_bus_o = addr_last_reg;
  assign host_address_bus_oe = addr_hold_en & ~host_address_bus_oe_ext;

endmodule

// ---- hdl/host_port_pkg.sv ----
// Constants, register map and types for the separate-bus host port.
// Assumes a single pclk domain and an APB register slave with 32-bit data.
//
// Summary of operation
// - Host reaches data through 16-bit two-way data bus and 19-bit address bus.
// - Address bit 18 low selects local data memory, high selects shared program memory.
// - Device stalls the host with ready low; host waits for ready before finishing.
// - Host control register is unreachable from the host in this mode.
// - Each host access becomes one internal DMA read or DMA write; the code refuses register-window accesses without any DMA.
// - Global or first-subsystem reset disables both data and address bus holders.
// - Holder enables live in the bank control register at offset 29h.
// - Bank control bit 2 enables the data-bus holder; resets to 0.
// - Bank control bit 1 enables the address-bus holder; resets to 0.
// - Bank control bits 15..3 and bit 0 always read as zero.
// - During CPU idle one or two, clocks are gated on per access only; the code keeps them on while the CPU is also halted.
// - Host port leaves reset independently of the CPU for code download.
// - Host port keeps serving while the CPU is halted by emulation.
// - Multiplexer connects the host bus to exactly one selected subsystem.
// - Select pins upper/lower: 00 A, 01 B, 10 C, 11 D.
// - Host memory view equals DMA map but excludes memory-mapped registers.
// - Ready holds off the host while the serving DMA transfer is pending.
package host_port_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Printed offset is not a multiple of four, so it is an index
  localparam logic [7:0] BANK_CTRL_INDEX = 8'h29;
  localparam logic [11:0] BANK_CTRL_ADDR = {2'h0, BANK_CTRL_INDEX, 2'h0};
  localparam logic [7:0] PORT_STATUS_INDEX = 8'h2A;
  localparam logic [11:0] PORT_STATUS_ADDR = {2'h0, PORT_STATUS_INDEX, 2'h0};
  localparam logic [7:0] MMR_LIMIT_INDEX = 8'h2B;
  localparam logic [11:0] MMR_LIMIT_ADDR = {2'h0, MMR_LIMIT_INDEX, 2'h0};
  localparam int BANK_DATA_HOLD_BIT = 2;
  localparam int BANK_ADDR_HOLD_BIT = 1;
  localparam logic [15:0] BANK_CTRL_RESET = 16'h0000;
  localparam logic [15:0] BANK_CTRL_MASK = 16'h0006;
  // Default top of the memory-mapped register area in data page 0
  localparam logic [15:0] MMR_LIMIT_RESET = 16'h005F;

  // ---------------------------------------------------------------
  // Host bus geometry
  // ---------------------------------------------------------------
  localparam int HOST_DATA_W = 16;
  localparam int HOST_ADDR_W = 19;
  localparam int SPACE_BIT = 18;
  localparam int SUBSYS_N = 4;

  // Host port sequencer states
  typedef enum logic [2:0] {
    HP_IDLE,
    HP_WAKE,
    HP_DMA,
    HP_DONE,
    HP_REJECT
  } host_state_t;

endpackage

// ---- hdl/dma_link_if.sv ----
// DMA request/answer bundle between host port and memory selector.
// Assumes one pclk domain; request holds until gnt.
`timescale 1ns/10ps
interface dma_link_if;
  logic req;
  logic wr;
  logic shared;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic gnt;
  logic [15:0] rdata;
  modport port (output req, wr, shared, addr, wdata, input gnt, rdata);
  modport mem (input req, wr, shared, addr, wdata, output gnt, rdata);
endinterface

// ---- hdl/subsys_select.sv ----
// Host bus multiplexer: one DMA request reaches exactly one subsystem.
// Assumes select pins are synchronous and stable during an access.
`timescale 1ns/10ps
module subsys_select (
  input wire logic [1:0] sel,             // Upper/lower select pins
  dma_link_if.mem link,                   // Request from the host port
  output logic [3:0] sub_req,             // One request line per subsystem
  input wire logic [3:0] sub_gnt,         // Grant from each subsystem
  input wire logic [63:0] sub_rdata       // Read data, 16 bits per subsystem
);

  // ---------------------------------------------------------------
  // One-hot steering
  // ---------------------------------------------------------------
  // Only the picked subsystem ever sees a request
  always_comb begin
    sub_req = 4'h0;
    sub_req[sel] = link.req;
  end

  assign link.gnt = sub_gnt[sel];
  assign link.rdata = sub_rdata[sel*16 +: 16];

endmodule

// ---- verification/host_port_nonmux_sva.sv ----
// Assertion checker for the separate-bus host port top module.
// Assumes the host holds address and select until ready.
`timescale 1ns/10ps
module host_port_nonmux_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic sub_a_resetn, // Sub A reset
  input wire logic [11:0] paddr, // APB addr
  input wire logic psel, // APB sel
  input wire logic penable, // APB phase
  input wire logic pwrite, // APB dir
  input wire logic [31:0] prdata, // APB data
  input wire logic [18:0] host_address_bus_i, // Addr in
  input wire logic host_address_bus_oe_ext, // Addr driven
  input wire logic [18:0] host_address_bus_o, // Holder value
  input wire logic host_address_bus_oe, // Holder on
  input wire logic host_data_bus_oe, // Data drive
  input wire logic host_data_strobe_one_n, // Strobe 1
  input wire logic host_data_strobe_two_n, // Strobe 2
  input wire logic host_chip_select_n, // Select
  input wire logic host_ready, // Ready
  input wire logic port_select_low, // Sel low
  input wire logic port_select_high, // Sel high
  input wire logic cpu_idle, // Idle
  input wire logic mem_clk_en, // Clock req
  input wire logic [3:0] sub_req, // DMA req
  input wire logic sub_shared, // Shared
  input wire logic [17:0] sub_addr, // DMA addr
  input wire logic [3:0] sub_gnt // Grant
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------
  // Access decode
  // -------------------------------------------
  logic acc;
  logic mmr;
  assign acc = !host_chip_select_n && !host_data_strobe_one_n && !host_data_strobe_two_n;
  // Register window uses the reset limit; the bench never moves it
  assign mmr = !host_address_bus_i[18] && host_address_bus_i[17:0] <= 18'h0005F;
  a_ready_low_start: assert property ($rose(acc) |-> !host_ready)
    else $error("ready high at access start");
  a_dma_start: assert property ($rose(acc) && !mmr |-> ##[2:4] sub_req != 4'h0)
    else $error("no DMA request");
  a_refuse_none: assert property ($rose(acc) && mmr |-> (sub_req == 4'h0) [*4])
    else $error("DMA to register window");
  a_space_route: assert property (sub_req != 4'h0 |->
    sub_shared == host_address_bus_i[18] && sub_addr == host_address_bus_i[17:0])
    else $error("bad DMA address");
  a_mux_select: assert property (sub_req != 4'h0 |->
    sub_req == 4'h1 << {port_select_high, port_select_low})
    else $error("wrong subsystem");
  a_req_hold: assert property (sub_req != 4'h0 && (sub_req & sub_gnt) == 4'h0 |=>
    sub_req == $past(sub_req) && !host_ready)
    else $error("request dropped");
  a_ready_after_gnt: assert property ((sub_req & sub_gnt) != 4'h0 |=> host_ready)
    else $error("no ready after grant");
  a_holder_reset: assert property (!sub_a_resetn |-> !host_address_bus_oe && !host_data_bus_oe)
    else $error("holder on in reset");
  a_holder_last: assert property ($fell(host_address_bus_oe_ext) && host_address_bus_oe |->
    host_address_bus_o == $past(host_address_bus_i))
    else $error("holder lost level");
  a_reserved_zero: assert property (psel && penable && !pwrite && paddr == host_port_pkg::BANK_CTRL_ADDR |->
    prdata[31:3] == 29'h0 && !prdata[0])
    else $error("reserved bits set");
  a_idle_clock: assert property (cpu_idle && sub_req != 4'h0 |-> mem_clk_en)
    else $error("no clock in idle");
  c_refused: cover property ($rose(acc) && mmr);
  c_shared: cover property ((sub_req & sub_gnt) != 4'h0 && sub_shared);
  c_holders: cover property (host_address_bus_oe && host_data_bus_oe);
endmodule

// ---- verification/host_cpu_model.sv ----
// Model of the external host with separate address and data buses.
// Assumes the bench resolves the wires and feeds the data wire back.
`timescale 1ns/10ps
module host_cpu_model (
  input wire logic pclk, // Clock
  input wire logic host_ready, // Ready
  input wire logic [15:0] data_wire, // Resolved data
  output logic [18:0] addr, // Addr drive
  output logic addr_drv, // Addr driven
  output logic [15:0] data, // Data drive
  output logic data_drv, // Data driven
  output logic strobe_one_n, // Strobe 1
  output logic strobe_two_n, // Strobe 2
  output logic cs_n, // Chip select
  output logic rw, // High read
  output logic sel_low, // Select lower
  output logic sel_high // Select upper
);
  initial begin
    {addr, addr_drv, data, data_drv, rw, sel_low, sel_high} = '0;
    {strobe_one_n, strobe_two_n, cs_n} = 3'h7;
  end
  // Select settles a cycle early so no access straddles two subsystems
  task automatic xfer(input logic r, input logic [1:0] s, input logic [18:0] a, input logic [15:0] wd,
                      output logic [15:0] q, output logic ok);
    int n;
    @(posedge pclk);
    {sel_high, sel_low} <= s;
    @(posedge pclk);
    addr <= a;
    addr_drv <= 1'b1;
    rw <= r;
    data <= wd;
    data_drv <= !r;
    {strobe_one_n, strobe_two_n, cs_n} <= 3'h0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (host_ready !== 1'b1 && n < 40);
    q = data_wire;
    ok = n < 40;
    {strobe_one_n, strobe_two_n, cs_n} <= 3'h7;
    // Released lines show the inverse so a stale level cannot pass
    addr <= ~a;
    addr_drv <= 1'b0;
    data <= ~wd;
    data_drv <= 1'b0;
  endtask
endmodule

// ---- verification/host_port_nonmux_tb.sv ----
// Self-checking bench for the separate-bus host port.
// Assumes the host model and a DMA responder stand on the far side.
`timescale 1ns/10ps
module host_port_nonmux_tb;
  typedef struct packed {
    logic rd;
    logic [1:0] sel;
    logic [18:0] addr;
    logic [15:0] data;
    logic idle;
    logic [1:0] lag;
  } row_t;
  row_t rows [9] = '{'{1'b0, 2'h0, 19'h00101, 16'h1234, 1'b0, 2'h0}, '{1'b0, 2'h1, 19'h40102, 16'hABCD, 1'b1, 2'h2},
    '{1'b0, 2'h2, 19'h10103, 16'h5A5A, 1'b0, 2'h3}, '{1'b0, 2'h3, 19'h3FF04, 16'h0FF0, 1'b1, 2'h1},
    '{1'b1, 2'h0, 19'h00101, 16'h1234, 1'b1, 2'h3}, '{1'b1, 2'h1, 19'h40102, 16'hABCD, 1'b0, 2'h0},
    '{1'b1, 2'h2, 19'h10103, 16'h5A5A, 1'b1, 2'h2}, '{1'b1, 2'h1, 19'h00102, 16'h0000, 1'b0, 2'h0},
    '{1'b1, 2'h3, 19'h3FF04, 16'h0FF0, 1'b0, 2'h1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sub_a_resetn = 1'b1;
  logic port_resetn = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic cpu_idle = 1'b0;
  logic cpu_halted = 1'b0;
  logic [3:0] sub_gnt = 4'h0;
  logic [1:0] lag = 2'h0;
  logic [1:0] lag_set = 2'h0;
  logic [31:0] prdata, rdv;
  logic [18:0] a_host, a_o, a_wire;
  logic [15:0] d_host, d_o, d_wire, sub_wdata, q;
  logic [15:0] mem [0:127];
  logic [17:0] sub_addr;
  logic [3:0] sub_req;
  logic [6:0] key;
  logic pready, pslverr, a_drv, a_oe, d_drv, d_oe, s1_n, s2_n, cs_n, rw, sel_lo, sel_hi, h_rdy;
  logic sub_wr, sub_shared, err, ok;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 pclk = ~pclk;
  // Wire levels resolved from the port's drive enables; host levels otherwise
  assign a_wire = a_oe ? a_o : a_host;
  assign d_wire = d_oe ? d_o : d_host;
  assign key = {sub_req[3] | sub_req[2], sub_req[3] | sub_req[1], sub_shared, sub_addr[3:0]};
  // DMA side grants after a per-row lag, so slow memory is exercised too
  always @(posedge pclk) begin
    sub_gnt <= 4'h0;
    if (sub_req == 4'h0) begin
      lag <= lag_set;
    end else if (sub_gnt == 4'h0 && lag != 2'h0) begin
      lag <= lag - 2'h1;
    end else if (sub_gnt == 4'h0) begin
      sub_gnt <= sub_req;
      if (sub_wr) begin
        mem[key] <= sub_wdata;
      end
    end
  end
  host_port_nonmux i_host_port_nonmux (
    .pclk, .presetn, .sub_a_resetn, .port_resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .host_address_bus_i(a_wire), .host_address_bus_oe_ext(a_drv),
    .host_address_bus_o(a_o), .host_address_bus_oe(a_oe), .host_data_bus_i(d_wire), .host_data_bus_o(d_o),
    .host_data_bus_oe(d_oe), .host_data_bus_host_oe(d_drv), .host_data_strobe_one_n(s1_n),
    .host_data_strobe_two_n(s2_n), .host_chip_select_n(cs_n), .host_read_write(rw), .host_ready(h_rdy),
    .port_select_low(sel_lo), .port_select_high(sel_hi), .cpu_idle, .cpu_halted, .mem_clk_en(),
    .sub_req, .sub_wr, .sub_shared, .sub_addr, .sub_wdata, .sub_gnt, .sub_rdata({4{mem[key]}})
  );
  host_cpu_model i_host_cpu_model (
    .pclk, .host_ready(h_rdy), .data_wire(d_wire), .addr(a_host), .addr_drv(a_drv), .data(d_host),
    .data_drv(d_drv), .strobe_one_n(s1_n), .strobe_two_n(s2_n), .cs_n, .rw, .sel_low(sel_lo), .sel_high(sel_hi)
  );
  // -------------------------------------------
  // Tasks
  // -------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic final_report(input logic hung);
    if (hung)
      n_mismatch++;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 20)
      final_report(1'b1);
  endtask
  task automatic host(input logic r, input logic [1:0] s, input logic [18:0] a, input logic [15:0] wd);
    i_host_cpu_model.xfer(r, s, a, wd, q, ok);
    if (!ok)
      final_report(1'b1);
  endtask
  // -------------------------------------------
  // Sequence
  // -------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++)
      mem[i] = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, host_port_pkg::BANK_CTRL_ADDR, 32'h0);
    chk("bank reset", 32'h0, rdv);
    foreach (rows[i]) begin
      cpu_idle <= rows[i].idle;
      cpu_halted <= rows[i].idle;
      lag_set <= rows[i].lag;
      host(rows[i].rd, rows[i].sel, rows[i].addr, rows[i].data);
      if (rows[i].rd)
        chk("host read", {16'h0, rows[i].data}, {16'h0, q});
    end
    // Register window is refused and reads back as zero
    host(1'b1, 2'h0, 19'h00020, 16'h0000);
    chk("refused read", 32'h0, {16'h0, q});
    // Last row left nonzero read data, so a missing clear on refusal shows up in the refused read above
    apb(1'b0, host_port_pkg::PORT_STATUS_ADDR, 32'h0);
    chk("reject flag", 32'h1, {31'h0, rdv[7]});
    chk("access count", 32'h00000009, {16'h0, rdv[31:16]});
    apb(1'b1, host_port_pkg::PORT_STATUS_ADDR, 32'h00000080);
    apb(1'b0, host_port_pkg::PORT_STATUS_ADDR, 32'h0);
    chk("reject clear", 32'h0, {31'h0, rdv[7]});
    apb(1'b0, host_port_pkg::MMR_LIMIT_ADDR, 32'h0);
    chk("mmr limit", {16'h0, host_port_pkg::MMR_LIMIT_RESET}, rdv);
    apb(1'b1, host_port_pkg::BANK_CTRL_ADDR, 32'hFFFFFFFF);
    apb(1'b0, host_port_pkg::BANK_CTRL_ADDR, 32'h0);
    chk("bank ctrl", 32'h6, rdv);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    host(1'b0, 2'h0, 19'h00123, 16'h1357);
    @(posedge pclk);
    #1;
    chk("addr holder", {12'h0, 1'b1, 19'h00123}, {12'h0, a_oe, a_o});
    chk("data holder", {15'h0, 1'b1, 16'h1357}, {15'h0, d_oe, d_o});
    @(posedge pclk);
    sub_a_resetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk("holders in reset", 32'h0, {30'h0, a_oe, d_oe});
    @(posedge pclk);
    sub_a_resetn <= 1'b1;
    apb(1'b0, host_port_pkg::BANK_CTRL_ADDR, 32'h0);
    chk("bank after reset", 32'h0, rdv);
    // Port leaves its own reset while the CPU stays halted
    @(posedge pclk);
    port_resetn <= 1'b0;
    cpu_halted <= 1'b1;
    @(posedge pclk);
    port_resetn <= 1'b1;
    host(1'b1, 2'h2, 19'h10103, 16'h0000);
    chk("read after port reset", 32'h5A5A, {16'h0, q});
    final_report(1'b0);
  end
endmodule
bind host_port_nonmux host_port_nonmux_chk i_chk (
  .pclk, .presetn, .sub_a_resetn, .paddr, .psel, .penable, .pwrite, .prdata, .host_address_bus_i,
  .host_address_bus_oe_ext, .host_address_bus_o, .host_address_bus_oe, .host_data_bus_oe,
  .host_data_strobe_one_n, .host_data_strobe_two_n, .host_chip_select_n, .host_ready, .port_select_low,
  .port_select_high, .cpu_idle, .mem_clk_en, .sub_req, .sub_shared, .sub_addr, .sub_gnt
);
